// ---- hdl/sfc_config_regs.vh ----
// Register map, field layout and decode constants for the sensing front-end configuration bank
`ifndef SFC_CONFIG_REGS_VH
`define SFC_CONFIG_REGS_VH

// Byte addresses
`define SFC_ADDR_TX_SELECT      16'h11c6
`define SFC_TX_SELECT_BYTES     3'h6
`define SFC_ADDR_TP_FRACTION    16'h11d8
`define SFC_ADDR_TP_FIRST_PERIOD_VALUE     16'h11d9
`define SFC_ADDR_TP_SECOND_PERIOD_VALUE     16'h11da
`define SFC_ADDR_ALT_FRACTION   16'h11db
`define SFC_ADDR_ALT_FIRST_PERIOD_VALUE    16'h11dc
`define SFC_ADDR_ALT_SECOND_PERIOD_VALUE    16'h11dd
`define SFC_ADDR_TP_SETTINGS    16'h11de
`define SFC_ADDR_TP_SETTINGS_HI 16'h11df
`define SFC_ADDR_ALT_SETTINGS   16'h11e0
`define SFC_ADDR_ALT_SETTINGS_HI 16'h11e1

// Tx select mask layout
`define SFC_TX_LIVE_MASK        48'h2fffffffffff
`define SFC_TX_READ_MASK        48'h3fffffffffff

// Setting word fields
`define SFC_F_INIT_DELAY        15:14
`define SFC_F_BIAS              13:11
`define SFC_F_COUNT_LIMIT       10:8
`define SFC_F_DISCHARGE         7
`define SFC_F_RF_FILTER         6
`define SFC_F_OUT_STATIC        5
`define SFC_F_IN_STATIC         4
`define SFC_F_OFFSET_SIGN       3
`define SFC_F_OFFSET_MAG        2:0
`define SFC_F_OFFSET            3:0

// Initial cycle counts
`define SFC_INIT_CODE0          9'h010
`define SFC_INIT_CODE1          9'h020
`define SFC_INIT_CODE2          9'h040
`define SFC_INIT_CODE3          9'h100

// Count limits
`define SFC_LIMIT_CODE0         11'h17f
`define SFC_LIMIT_CODE1         11'h1ff
`define SFC_LIMIT_CODE2         11'h2ff
`define SFC_LIMIT_CODE3         11'h3ff
`define SFC_LIMIT_CODE4         11'h7ff

// Reset values
`define SFC_RESET_BYTE          8'h00
`define SFC_RESET_WORD          16'h0000
`define SFC_RESET_TX            48'h000000000000

// Sequencer states
`define SFC_ST_IDLE             2'h0
`define SFC_ST_INIT             2'h1
`define SFC_ST_COUNT            2'h2

`endif

// ---- hdl/sfc_config_bank.v ----
// Sensing front-end configuration register bank with per-channel conversion sequencers
`timescale 1ns/10ps
`include "sfc_config_regs.vh"

module sfc_config_bank (
   input  wire        clock,
   input  wire        nrst,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [15:0] reg_addr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   input  wire [1:0]  conv_start,
   input  wire [1:0]  conv_tick,
   output reg  [47:0] tx_select,
   output wire [1:0]  conv_busy,
   output wire [1:0]  conv_init_phase,
   output wire [1:0]  conv_done,
   output wire [21:0] conv_count,
   output wire [15:0] freq_fraction,
   output wire [15:0] first_period_value,
   output wire [15:0] second_period_value,
   output wire [17:0] initial_cycles,
   output wire [21:0] count_limit,
   output wire [5:0]  sample_hold_bias_code,
   output wire [1:0]  discharge_half_volt,
   output wire [1:0]  rf_filter_en,
   output wire [1:0]  outward_static_noise_option,
   output wire [1:0]  inward_static_noise_option,
   output wire [7:0]  sample_hold_offset_code,
   output wire [9:0]  sample_hold_offset_mv
);

   // Stored register contents
   reg  [47:0] alternate_channel_tx_select;
   reg  [7:0]  trackpad_freq_fraction;
   reg  [7:0]  trackpad_freq_period_first;
   reg  [7:0]  trackpad_freq_period_second;
   reg  [7:0]  alternate_freq_fraction;
   reg  [7:0]  alternate_freq_period_first;
   reg  [7:0]  alternate_freq_period_second;
   reg  [15:0] trackpad_frontend_settings;
   reg  [15:0] alternate_frontend_settings;

   // Tx select window decode
   wire [15:0] tx_offset;
   wire        tx_hit;
   wire [2:0]  tx_idx;
   wire [47:0] tx_readable;

   assign tx_offset   = reg_addr - `SFC_ADDR_TX_SELECT;
   assign tx_hit      = (reg_addr >= `SFC_ADDR_TX_SELECT) &&
                        (tx_offset < {13'h0000, `SFC_TX_SELECT_BYTES});
   assign tx_idx      = tx_offset[2:0];
   assign tx_readable = alternate_channel_tx_select & `SFC_TX_READ_MASK;

   // Host writes, one byte per access, low byte at the lower address
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         alternate_channel_tx_select  <= `SFC_RESET_TX;
         trackpad_freq_fraction       <= `SFC_RESET_BYTE;
         trackpad_freq_period_first   <= `SFC_RESET_BYTE;
         trackpad_freq_period_second  <= `SFC_RESET_BYTE;
         alternate_freq_fraction      <= `SFC_RESET_BYTE;
         alternate_freq_period_first  <= `SFC_RESET_BYTE;
         alternate_freq_period_second <= `SFC_RESET_BYTE;
         trackpad_frontend_settings   <= `SFC_RESET_WORD;
         alternate_frontend_settings  <= `SFC_RESET_WORD;
      end else if (reg_wr) begin
         if (tx_hit) begin
            alternate_channel_tx_select[tx_idx*8 +: 8] <= reg_wdata;
         end
         case (reg_addr)
            `SFC_ADDR_TP_FRACTION:      trackpad_freq_fraction <= reg_wdata;
            `SFC_ADDR_TP_FIRST_PERIOD_VALUE:       trackpad_freq_period_first <= reg_wdata;
            `SFC_ADDR_TP_SECOND_PERIOD_VALUE:       trackpad_freq_period_second <= reg_wdata;
            `SFC_ADDR_ALT_FRACTION:     alternate_freq_fraction <= reg_wdata;
            `SFC_ADDR_ALT_FIRST_PERIOD_VALUE:      alternate_freq_period_first <= reg_wdata;
            `SFC_ADDR_ALT_SECOND_PERIOD_VALUE:      alternate_freq_period_second <= reg_wdata;
            `SFC_ADDR_TP_SETTINGS:      trackpad_frontend_settings[7:0] <= reg_wdata;
            `SFC_ADDR_TP_SETTINGS_HI:   trackpad_frontend_settings[15:8] <= reg_wdata;
            `SFC_ADDR_ALT_SETTINGS:     alternate_frontend_settings[7:0] <= reg_wdata;
            `SFC_ADDR_ALT_SETTINGS_HI:  alternate_frontend_settings[15:8] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data, registered; unmapped addresses and unused bits read zero
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= `SFC_RESET_BYTE;
      end else if (reg_rd) begin
         if (tx_hit) begin
            reg_rdata <= tx_readable[tx_idx*8 +: 8];
         end else begin
            case (reg_addr)
               `SFC_ADDR_TP_FRACTION:      reg_rdata <= trackpad_freq_fraction;
               `SFC_ADDR_TP_FIRST_PERIOD_VALUE:       reg_rdata <= trackpad_freq_period_first;
               `SFC_ADDR_TP_SECOND_PERIOD_VALUE:       reg_rdata <= trackpad_freq_period_second;
               `SFC_ADDR_ALT_FRACTION:     reg_rdata <= alternate_freq_fraction;
               `SFC_ADDR_ALT_FIRST_PERIOD_VALUE:      reg_rdata <= alternate_freq_period_first;
               `SFC_ADDR_ALT_SECOND_PERIOD_VALUE:      reg_rdata <= alternate_freq_period_second;
               `SFC_ADDR_TP_SETTINGS:      reg_rdata <= trackpad_frontend_settings[7:0];
               `SFC_ADDR_TP_SETTINGS_HI:   reg_rdata <= trackpad_frontend_settings[15:8];
               `SFC_ADDR_ALT_SETTINGS:     reg_rdata <= alternate_frontend_settings[7:0];
               `SFC_ADDR_ALT_SETTINGS_HI:  reg_rdata <= alternate_frontend_settings[15:8];
               default:                    reg_rdata <= `SFC_RESET_BYTE;
            endcase
         end
      end
   end

   // Electrode mask: bit 44 and bits 47..46 never reach the sensor
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tx_select <= `SFC_RESET_TX;
      end else begin
         tx_select <= alternate_channel_tx_select & `SFC_TX_LIVE_MASK;
      end
   end

   // Initial cycle decode
   function [8:0] init_decode;
      input [1:0] code;
      begin
         case (code)
            2'h0:    init_decode = `SFC_INIT_CODE0;
            2'h1:    init_decode = `SFC_INIT_CODE1;
            2'h2:    init_decode = `SFC_INIT_CODE2;
            default: init_decode = `SFC_INIT_CODE3;
         endcase
      end
   endfunction

   // Count limit decode; codes above 100 fall back to the largest limit
   function [10:0] limit_decode;
      input [2:0] code;
      begin
         case (code)
            3'h0:    limit_decode = `SFC_LIMIT_CODE0;
            3'h1:    limit_decode = `SFC_LIMIT_CODE1;
            3'h2:    limit_decode = `SFC_LIMIT_CODE2;
            3'h3:    limit_decode = `SFC_LIMIT_CODE3;
            default: limit_decode = `SFC_LIMIT_CODE4;
         endcase
      end
   endfunction

   // Sources per channel: index 0 trackpad, index 1 alternate channel
   wire [15:0] src_fraction;
   wire [15:0] src_first_period_value;
   wire [15:0] src_second_period_value;
   wire [31:0] src_settings;

   assign src_fraction = {alternate_freq_fraction, trackpad_freq_fraction};
   assign src_first_period_value  = {alternate_freq_period_first, trackpad_freq_period_first};
   assign src_second_period_value  = {alternate_freq_period_second, trackpad_freq_period_second};
   assign src_settings = {alternate_frontend_settings, trackpad_frontend_settings};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         reg  [1:0]  state;
         reg  [8:0]  init_cnt;
         reg  [10:0] cnt;
         reg         done;
         reg  [7:0]  act_fraction;
         reg  [7:0]  act_first_period_value;
         reg  [7:0]  act_second_period_value;
         reg  [8:0]  act_init;
         reg  [10:0] act_limit;
         reg  [2:0]  act_bias;
         reg         act_discharge;
         reg         act_rf;
         reg         act_out_static;
         reg         act_in_static;
         reg  [3:0]  act_offset;
         reg  [4:0]  act_offset_mv;
         wire [15:0] word;
         wire [4:0]  mag_mv;

         assign word   = src_settings[ch*16 +: 16];
         assign mag_mv = {1'b0, word[`SFC_F_OFFSET_MAG], 1'b0};

         // Settings latch at conversion start, then initial delay, then counting
         always @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               state          <= `SFC_ST_IDLE;
               init_cnt       <= 9'h000;
               cnt            <= 11'h000;
               done           <= 1'b0;
               act_fraction   <= `SFC_RESET_BYTE;
               act_first_period_value    <= `SFC_RESET_BYTE;
               act_second_period_value    <= `SFC_RESET_BYTE;
               act_init       <= `SFC_INIT_CODE0;
               act_limit      <= `SFC_LIMIT_CODE0;
               act_bias       <= 3'h0;
               act_discharge  <= 1'b0;
               act_rf         <= 1'b0;
               act_out_static <= 1'b0;
               act_in_static  <= 1'b0;
               act_offset     <= 4'h0;
               act_offset_mv  <= 5'h00;
            end else begin
               done <= 1'b0;
               case (state)
                  `SFC_ST_IDLE: begin
                     if (conv_start[ch]) begin
                        act_fraction   <= src_fraction[ch*8 +: 8];
                        act_first_period_value    <= src_first_period_value[ch*8 +: 8];
                        act_second_period_value    <= src_second_period_value[ch*8 +: 8];
                        act_init       <= init_decode(word[`SFC_F_INIT_DELAY]);
                        act_limit      <= limit_decode(word[`SFC_F_COUNT_LIMIT]);
                        act_bias       <= word[`SFC_F_BIAS];
                        act_discharge  <= word[`SFC_F_DISCHARGE];
                        act_rf         <= word[`SFC_F_RF_FILTER];
                        act_out_static <= word[`SFC_F_OUT_STATIC];
                        act_in_static  <= word[`SFC_F_IN_STATIC];
                        act_offset     <= word[`SFC_F_OFFSET];
                        act_offset_mv  <= word[`SFC_F_OFFSET_SIGN] ? mag_mv :
                                          (5'h00 - mag_mv);
                        init_cnt       <= 9'h000;
                        cnt            <= 11'h000;
                        state          <= `SFC_ST_INIT;
                     end
                  end
                  `SFC_ST_INIT: begin
                     if (conv_tick[ch]) begin
                        if (init_cnt == act_init - 9'h001) begin
                           state <= `SFC_ST_COUNT;
                        end else begin
                           init_cnt <= init_cnt + 9'h001;
                        end
                     end
                  end
                  `SFC_ST_COUNT: begin
                     if (conv_tick[ch]) begin
                        cnt <= cnt + 11'h001;
                        if (cnt + 11'h001 == act_limit) begin
                           done  <= 1'b1;
                           state <= `SFC_ST_IDLE;
                        end
                     end
                  end
                  default: state <= `SFC_ST_IDLE;
               endcase
            end
         end

         // Per-channel outputs from flip-flops; busy and init phase are decoded from state
         assign conv_busy[ch]                   = (state != `SFC_ST_IDLE);
         assign conv_init_phase[ch]             = (state == `SFC_ST_INIT);
         assign conv_done[ch]                   = done;
         assign conv_count[ch*11 +: 11]         = cnt;
         assign freq_fraction[ch*8 +: 8]        = act_fraction;
         assign first_period_value[ch*8 +: 8]   = act_first_period_value;
         assign second_period_value[ch*8 +: 8]  = act_second_period_value;
         assign initial_cycles[ch*9 +: 9]       = act_init;
         assign count_limit[ch*11 +: 11]        = act_limit;
         assign sample_hold_bias_code[ch*3 +: 3] = act_bias;
         assign discharge_half_volt[ch]         = act_discharge;
         assign rf_filter_en[ch]                = act_rf;
         assign outward_static_noise_option[ch] = act_out_static;
         assign inward_static_noise_option[ch]  = act_in_static;
         assign sample_hold_offset_code[ch*4 +: 4] = act_offset;
         assign sample_hold_offset_mv[ch*5 +: 5]   = act_offset_mv;
      end
   endgenerate

endmodule

// ---- testbench/sfc_config_checker.sv ----
// Port-level assertions for the front-end configuration bank
`timescale 1ns/10ps
module sfc_config_checker (
   input logic        clock,
   input logic        nrst,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [15:0] reg_addr,
   input logic [7:0]  reg_wdata,
   input logic [7:0]  reg_rdata,
   input logic [1:0]  conv_start,
   input logic [1:0]  conv_busy,
   input logic [1:0]  conv_init_phase,
   input logic [1:0]  conv_done,
   input logic [21:0] conv_count,
   input logic [47:0] tx_select,
   input logic [17:0] initial_cycles,
   input logic [21:0] count_limit,
   input logic [7:0]  sample_hold_offset_code,
   input logic [9:0]  sample_hold_offset_mv
);
   // Magnitude of the trackpad offset in millivolts
   wire [4:0] mag_mv = {1'b0, sample_hold_offset_code[2:0], 1'b0};
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // Register-side checks
   property p_tx_low; reg_wr && reg_addr == 16'h11c6 |=> ##1 tx_select[7:0] == $past(reg_wdata, 2); endproperty
   a_tx_low: assert property (p_tx_low) else $error("tx mask low byte not applied");
   property p_tx_rsv; tx_select[47:46] == 2'h0 && tx_select[44] == 1'b0; endproperty
   a_tx_rsv: assert property (p_tx_rsv) else $error("tx mask reserved bit live");
   property p_rd_gap; reg_rd && reg_addr == 16'h11e2 |=> reg_rdata == 8'h00; endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
   // Conversion-side checks
   property p_init_set; initial_cycles[8:0] inside {9'h010, 9'h020, 9'h040, 9'h100}; endproperty
   a_init_set: assert property (p_init_set) else $error("initial cycles off table");
   property p_done_cnt; conv_done[0] |-> conv_count[10:0] == count_limit[10:0]; endproperty
   a_done_cnt: assert property (p_done_cnt) else $error("done before limit");
   property p_done_pulse; conv_done[0] |=> !conv_done[0]; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   property p_alt_done; conv_done[1] |-> conv_count[21:11] == count_limit[21:11]; endproperty
   a_alt_done: assert property (p_alt_done) else $error("alternate done before limit");
   property p_start; conv_start[0] && !conv_busy[0] && !conv_done[0] |=> conv_busy[0] && conv_init_phase[0];
   endproperty
   a_start: assert property (p_start) else $error("start did not enter delay phase");
   property p_hold; conv_busy[0] && $past(conv_busy[0]) |-> $stable(count_limit[10:0]) && $stable(initial_cycles[8:0]);
   endproperty
   a_hold: assert property (p_hold) else $error("settings moved mid conversion");
   property p_offset; sample_hold_offset_mv[4:0] == (sample_hold_offset_code[3] ? mag_mv : 5'h00 - mag_mv); endproperty
   a_offset: assert property (p_offset) else $error("offset sign or size wrong");
endmodule
bind sfc_config_bank sfc_config_checker u_sfc_config_checker (
   .clock(clock), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_busy(conv_busy),
   .conv_init_phase(conv_init_phase), .conv_done(conv_done), .conv_count(conv_count),
   .tx_select(tx_select), .initial_cycles(initial_cycles), .count_limit(count_limit),
   .sample_hold_offset_code(sample_hold_offset_code), .sample_hold_offset_mv(sample_hold_offset_mv)
);

// ---- testbench/tb_sfc_config_bank.sv ----
// Self-checking bench for the front-end configuration bank
`timescale 1ns/10ps
module tb_sfc_config_bank;
   logic        clock, nrst, reg_wr, reg_rd;
   logic [15:0] reg_addr, w;
   logic [7:0]  reg_wdata;
   logic [1:0]  conv_start, conv_tick;
   wire  [7:0]  reg_rdata, sample_hold_offset_code;
   wire  [47:0] tx_select;
   wire  [1:0]  conv_busy, conv_init_phase, conv_done, discharge_half_volt, rf_filter_en;
   wire  [1:0]  outward_static_noise_option, inward_static_noise_option;
   wire  [21:0] conv_count, count_limit;
   wire  [15:0] freq_fraction, first_period_value, second_period_value;
   wire  [17:0] initial_cycles;
   wire  [5:0]  sample_hold_bias_code;
   wire  [9:0]  sample_hold_offset_mv;
   integer      miscompares = 0, tests_run = 0, seed = 32'h374d, cycles = 0, n, i;
   logic [7:0]  mem [16'h11c6:16'h11e2];
   int          init_tab [4] = '{16, 32, 64, 256};
   int          lim_tab [8] = '{383, 511, 767, 1023, 2047, 2047, 2047, 2047};
   byte         freq_tab [6] = '{4, 31, 31, 12, 9, 10};

   sfc_config_bank u_sfc_config_bank (
      .clock(clock), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
      .conv_tick(conv_tick), .tx_select(tx_select), .conv_busy(conv_busy),
      .conv_init_phase(conv_init_phase), .conv_done(conv_done), .conv_count(conv_count),
      .freq_fraction(freq_fraction), .first_period_value(first_period_value),
      .second_period_value(second_period_value), .initial_cycles(initial_cycles),
      .count_limit(count_limit), .sample_hold_bias_code(sample_hold_bias_code),
      .discharge_half_volt(discharge_half_volt), .rf_filter_en(rf_filter_en),
      .outward_static_noise_option(outward_static_noise_option),
      .inward_static_noise_option(inward_static_noise_option),
      .sample_hold_offset_code(sample_hold_offset_code), .sample_hold_offset_mv(sample_hold_offset_mv)
   );

   // Clock at 100 MHz
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 50000) begin
         miscompares = miscompares + 1;
         $display("BAD %0t run too long", $time);
         summarize;
      end
   end

   task summarize;
      $display("Counts: %0d compares, %0d mismatches", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   function automatic bit mapped(input logic [15:0] a);
      return (a <= 16'h11cb) || (a >= 16'h11d8 && a <= 16'h11e1);
   endfunction

   // Byte write; the model keeps what a read should return
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_wr = 0;
      if (mapped(a)) mem[a] = (a == 16'h11cb) ? (d & 8'h3f) : d;
   endtask

   task rd(input logic [15:0] a);
      @(negedge clock);
      reg_rd = 1;
      reg_addr = a;
      @(negedge clock);
      reg_rd = 0;
      chk(reg_rdata, mapped(a) ? mem[a] : 8'h00, "read");
   endtask

   // One conversion: two-cycle start (second refused), a write mid-run, random ticks
   task conv(input int c, input logic [15:0] s);
      logic [4:0] mv;
      mv = s[3] ? {1'b0, s[2:0], 1'b0} : 5'h00 - {1'b0, s[2:0], 1'b0};
      @(negedge clock);
      conv_start[c] = 1;
      repeat (2) @(negedge clock);
      conv_start[c] = 0;
      wr(16'h11de + 16'(2 * c), 8'($random(seed)));
      n = 0;
      repeat (10000) begin
         if (conv_done[c] === 1'b1) break;
         conv_tick[c] = 1'($random(seed));
         @(posedge clock);
         if (conv_tick[c]) n = n + 1;
         @(negedge clock);
      end
      conv_tick[c] = 0;
      chk(n, init_tab[s[15:14]] + lim_tab[s[10:8]], "tick total");
      chk(initial_cycles[c * 9 +: 9], init_tab[s[15:14]], "initial cycles");
      chk({count_limit[c * 11 +: 11], conv_count[c * 11 +: 11]}, {2{11'(lim_tab[s[10:8]])}}, "limit");
      chk(sample_hold_bias_code[c * 3 +: 3], s[13:11], "bias");
      chk({discharge_half_volt[c], rf_filter_en[c]}, s[7:6], "discharge and filter");
      chk({outward_static_noise_option[c], inward_static_noise_option[c]}, s[5:4], "noise");
      chk({sample_hold_offset_code[c * 4 +: 4], sample_hold_offset_mv[c * 5 +: 5]}, {s[3:0], mv}, "offset");
      chk({freq_fraction[c * 8 +: 8], first_period_value[c * 8 +: 8], second_period_value[c * 8 +: 8]},
          {mem[16'h11d8 + 3 * c], mem[16'h11d9 + 3 * c], mem[16'h11da + 3 * c]}, "frequency");
      chk(conv_busy[c], 1'b0, "busy after done");
   endtask

   // Main sequence
   initial begin
      nrst = 0;
      reg_wr = 0;
      reg_rd = 0;
      reg_addr = 0;
      reg_wdata = 0;
      conv_start = 0;
      conv_tick = 0;
      for (i = 16'h11c6; i <= 16'h11e2; i++) mem[i] = 8'h00;
      repeat (10) @(posedge clock);
      @(negedge clock);
      nrst = 1;
      chk(initial_cycles, {9'h010, 9'h010}, "reset delay");
      chk(count_limit, {11'd383, 11'd383}, "reset limit");
      chk(tx_select, 48'h0, "reset mask");
      for (i = 16'h11c6; i <= 16'h11e2; i++) rd(i);
      $display("Test reset done");
      // Random fill of the map and the gap; host keeps bit 44 clear
      for (i = 16'h11c6; i <= 16'h11e2; i++) wr(i, 8'($random(seed)) & (i == 16'h11cb ? 8'hef : 8'hff));
      for (i = 16'h11c6; i <= 16'h11e2; i++) rd(i);
      chk(tx_select, {mem[16'h11cb], mem[16'h11ca], mem[16'h11c9], mem[16'h11c8], mem[16'h11c7],
          mem[16'h11c6]} & 48'h2fffffffffff, "tx mask");
      $display("Test map done");
      for (i = 0; i < 6; i++) wr(16'h11d8 + 16'(i), freq_tab[i]);
      // Every delay and limit code across both channels
      for (i = 0; i < 8; i++) begin
         w = {i[1:0], 3'($random(seed)), i[2:0], 8'($random(seed))};
         wr(16'h11de + 16'(2 * (i % 2)), w[7:0]);
         wr(16'h11df + 16'(2 * (i % 2)), w[15:8]);
         conv(i % 2, w);
         $display("Test conversion %0d done", i);
      end
      summarize;
   end
endmodule
